/* File: hdl/pcgr_regs.svh */
`ifndef PCGR_REGS_SVH
`define PCGR_REGS_SVH
// ----------------------------------------
// widths
// ----------------------------------------
`define PCGR_AW 8
`define PCGR_DW 32
`define PCGR_BEW 4
`define PCGR_PSW 6
// ----------------------------------------
// offsets and reset values
// ----------------------------------------
`define PCGR_SYS_GATE_OFF 8'h14
`define PCGR_PB2_GATE_OFF 8'h18
`define PCGR_SYS_GATE_RST 32'h0000_0014
`define PCGR_PB2_GATE_RST 32'h0000_0000
`define PCGR_ZERO 32'h0000_0000
`define PCGR_ONE 32'h0000_0001
// ----------------------------------------
// system-bus gate bit positions
// ----------------------------------------
`define PCGR_B_FIRST_DMA 0
`define PCGR_B_SECOND_DMA 1
`define PCGR_B_SRAM_SLEEP 2
`define PCGR_B_FLASH_SLEEP 4
`define PCGR_B_CHECKSUM 6
`define PCGR_B_PORT_A 17
`define PCGR_B_PORT_F 22
`define PCGR_B_TOUCH_SENSE 24
// ----------------------------------------
// peripheral-bus-two gate bit positions
// ----------------------------------------
`define PCGR_B_SYSCONF_COMP 0
`define PCGR_B_SERIAL_SIX 5
`define PCGR_B_SERIAL_EIGHT 7
`define PCGR_B_CONVERTER 9
`define PCGR_B_ADV_TIMER_ONE 11
`define PCGR_B_FIRST_SERIAL_PERIPH 12
`define PCGR_B_SERIAL_ONE 14
`define PCGR_B_GEN_TIMER_FIFTEEN 16
`define PCGR_B_GEN_TIMER_SEVENTEEN 18
`define PCGR_B_DEBUG_UNIT 22
`endif

/* File: hdl/pcgr_pkg.sv */
package pcgr_pkg;
`include "pcgr_regs.svh"
    typedef logic [`PCGR_AW-1:0] pcgr_addr_t;
    typedef logic [`PCGR_DW-1:0] pcgr_word_t;
    typedef logic [`PCGR_BEW-1:0] pcgr_be_t;
    typedef logic [`PCGR_PSW-1:0] pcgr_psel_t;
    typedef enum logic [1:0]
    {
        PCGR_TGT_NONE = 2'b00,
        PCGR_TGT_SYS = 2'b01,
        PCGR_TGT_PB2 = 2'b10
    } pcgr_target_t;
endpackage

/* File: hdl/pcgr_gate_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface pcgr_gate_if;
    pcgr_pkg::pcgr_word_t sys_run;
    pcgr_pkg::pcgr_word_t pb2_run;
    modport src (output sys_run, output pb2_run);
    modport snk (input sys_run, input pb2_run);
endinterface // pcgr_gate_if
`default_nettype wire

/* File: hdl/pcgr_clock_gate.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pcgr_regs.svh"
module pcgr_clock_gate
(
    input wire logic mclk,
    pcgr_gate_if.snk gates,
    output logic [2*`PCGR_DW-1:0] gclk
);
    import pcgr_pkg::*;
    logic [2*`PCGR_DW-1:0] run;
    logic [2*`PCGR_DW-1:0] held;
    assign run = {gates.pb2_run, gates.sys_run};
    // ----------------------------------------
    // latch while the clock is low, so an enable change never clips a high phase
    // ----------------------------------------
    always_latch
    begin
        if (!mclk)
        begin
            held = run;
        end
    end
    assign gclk = {2*`PCGR_DW{mclk}} & held;
endmodule // pcgr_clock_gate
`default_nettype wire

/* File: hdl/pcgr_read_mask.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pcgr_regs.svh"
module pcgr_read_mask
(
    input wire logic mclk,
    input wire logic nrst,
    pcgr_gate_if.snk gates,
    input wire logic periph_rd,
    input wire pcgr_pkg::pcgr_psel_t periph_sel,
    input wire pcgr_pkg::pcgr_word_t periph_rdata,
    output logic periph_rd_valid,
    output pcgr_pkg::pcgr_word_t periph_rd_data
);
    import pcgr_pkg::*;
    wire [2*`PCGR_DW-1:0] run_all = {gates.pb2_run, gates.sys_run};
    wire sel_open = run_all[periph_sel];
    // a gated peripheral is never seen: its read returns zero
    wire pcgr_word_t next_data = (periph_rd && sel_open) ? periph_rdata : `PCGR_ZERO;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            periph_rd_valid <= 1'b0;
            periph_rd_data <= `PCGR_ZERO;
        end
        else
        begin
            periph_rd_valid <= periph_rd;
            periph_rd_data <= next_data;
        end
    end
endmodule // pcgr_read_mask
`default_nettype wire

/* File: hdl/pcgr_top.sv */
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "pcgr_regs.svh"
// How it works
// - system-bus gate at 0x14 resets to 0x0000_0014, sram and flash bits set.
// - system-bus gate takes word, half-word and byte writes with no wait.
// - reads of a peripheral whose clock is off return zero.
// - peripheral-bus-two gate writes wait while a bus-two transfer is busy.
// - every defined enable bit is read/write; a clear bit stops its clock, for bits 2 and 4 only in sleep.
// - system bits 0, 1, 6, 24 gate both dma units, checksum, touch sensing.
// - system bit 2 keeps the sram clock running in sleep.
// - system bit 4 keeps the flash interface clock running in sleep.
// - system bits 17 to 22 gate io ports a to f.
// - bus-two gate at 0x18 resets to zero; bit 0 gates sysconfig and comparator.
// - bus-two bits 5, 6, 7 gate serial six to eight, bit 9 converter.
// - bus-two bits 11, 12, 14 gate advanced timer, serial periph, serial one.
// - bus-two bits 16, 17, 18 gate general timers fifteen to seventeen.
// - bus-two bit 22 gates the debug unit; all other bits are reserved.
module pcgr_top
(
    input wire logic mclk,
    input wire logic nrst,
    input wire pcgr_pkg::pcgr_addr_t reg_addr,
    input wire pcgr_pkg::pcgr_word_t reg_wdata,
    input wire pcgr_pkg::pcgr_be_t reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output pcgr_pkg::pcgr_word_t reg_rdata,
    input wire logic periph_busy,
    input wire logic sleep_mode,
    input wire logic periph_rd,
    input wire pcgr_pkg::pcgr_psel_t periph_sel,
    input wire pcgr_pkg::pcgr_word_t periph_rdata,
    output logic periph_rd_valid,
    output pcgr_pkg::pcgr_word_t periph_rd_data,
    output pcgr_pkg::pcgr_word_t system_bus_clock_gate,
    output pcgr_pkg::pcgr_word_t periph_bus_two_clock_gate,
    output logic pb2_write_wait,
    output logic [2*`PCGR_DW-1:0] gclk
);
    import pcgr_pkg::*;

    // ----------------------------------------
    // writable bit masks
    // ----------------------------------------
    function automatic pcgr_word_t span(input int lo, input int hi);
        pcgr_word_t m;
        m = `PCGR_ZERO;
        for (int i = lo; i <= hi; i++)
        begin
            m = m | (`PCGR_ONE << i);
        end
        return m;
    endfunction

    localparam pcgr_word_t SYS_MASK =
        span(`PCGR_B_FIRST_DMA, `PCGR_B_SECOND_DMA)
        | span(`PCGR_B_SRAM_SLEEP, `PCGR_B_SRAM_SLEEP)
        | span(`PCGR_B_FLASH_SLEEP, `PCGR_B_FLASH_SLEEP)
        | span(`PCGR_B_CHECKSUM, `PCGR_B_CHECKSUM)
        | span(`PCGR_B_PORT_A, `PCGR_B_PORT_F)
        | span(`PCGR_B_TOUCH_SENSE, `PCGR_B_TOUCH_SENSE);
    localparam pcgr_word_t PB2_MASK =
        span(`PCGR_B_SYSCONF_COMP, `PCGR_B_SYSCONF_COMP)
        | span(`PCGR_B_SERIAL_SIX, `PCGR_B_SERIAL_EIGHT)
        | span(`PCGR_B_CONVERTER, `PCGR_B_CONVERTER)
        | span(`PCGR_B_ADV_TIMER_ONE, `PCGR_B_FIRST_SERIAL_PERIPH)
        | span(`PCGR_B_SERIAL_ONE, `PCGR_B_SERIAL_ONE)
        | span(`PCGR_B_GEN_TIMER_FIFTEEN, `PCGR_B_GEN_TIMER_SEVENTEEN)
        | span(`PCGR_B_DEBUG_UNIT, `PCGR_B_DEBUG_UNIT);
    localparam pcgr_word_t SLEEP_KEEP =
        span(`PCGR_B_SRAM_SLEEP, `PCGR_B_SRAM_SLEEP)
        | span(`PCGR_B_FLASH_SLEEP, `PCGR_B_FLASH_SLEEP);

    // byte-lane merge; reserved bits never take a written one
    function automatic pcgr_word_t merge(input pcgr_word_t old, input pcgr_word_t wd,
        input pcgr_be_t be, input pcgr_word_t mask);
        pcgr_word_t r;
        r = old;
        for (int b = 0; b < `PCGR_BEW; b++)
        begin
            if (be[b])
            begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire sys_hit = (reg_addr == `PCGR_SYS_GATE_OFF);
    wire pb2_hit = (reg_addr == `PCGR_PB2_GATE_OFF);
    wire pcgr_target_t target = sys_hit ? PCGR_TGT_SYS : (pb2_hit ? PCGR_TGT_PB2 : PCGR_TGT_NONE);
    wire sys_wr = reg_wr && (target == PCGR_TGT_SYS);
    wire pb2_wr = reg_wr && (target == PCGR_TGT_PB2);

    // ----------------------------------------
    // system-bus gate: written at once, never waits
    // ----------------------------------------
    wire pcgr_word_t next_sys = merge(system_bus_clock_gate, reg_wdata, reg_be, SYS_MASK);
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            system_bus_clock_gate <= `PCGR_SYS_GATE_RST;
        end
        else if (sys_wr)
        begin
            system_bus_clock_gate <= next_sys;
        end
    end

    // ----------------------------------------
    // bus-two gate: a write during a bus-two transfer is held until it ends
    // ----------------------------------------
    // the master is never stalled; the held value lands once the bus is idle
    pcgr_word_t pend_value;
    wire pcgr_word_t pb2_base = pb2_write_wait ? pend_value : periph_bus_two_clock_gate;
    wire pcgr_word_t next_pb2 = merge(pb2_base, reg_wdata, reg_be, PB2_MASK);
    wire pb2_defer = pb2_wr && periph_busy;
    wire pb2_now = pb2_wr && !periph_busy;
    wire pb2_drain = pb2_write_wait && !periph_busy && !pb2_wr;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            periph_bus_two_clock_gate <= `PCGR_PB2_GATE_RST;
        end
        else if (pb2_now)
        begin
            periph_bus_two_clock_gate <= next_pb2;
        end
        else if (pb2_drain)
        begin
            periph_bus_two_clock_gate <= pend_value;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pb2_write_wait <= 1'b0;
            pend_value <= `PCGR_ZERO;
        end
        else if (pb2_defer)
        begin
            pb2_write_wait <= 1'b1;
            pend_value <= next_pb2;
        end
        else if (!periph_busy)
        begin
            pb2_write_wait <= 1'b0;
        end
    end

    // ----------------------------------------
    // read port: data in the cycle after the strobe only
    // ----------------------------------------
    wire pcgr_word_t read_sel = (target == PCGR_TGT_SYS) ? system_bus_clock_gate
        : ((target == PCGR_TGT_PB2) ? periph_bus_two_clock_gate : `PCGR_ZERO);
    wire pcgr_word_t next_rdata = reg_rd ? read_sel : `PCGR_ZERO;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata <= `PCGR_ZERO;
        end
        else
        begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // clock gates and gated-read masking
    // ----------------------------------------
    pcgr_gate_if gate_bus ();
    // sram and flash clocks run while awake; in sleep only if their bit is set
    assign gate_bus.sys_run = system_bus_clock_gate | (sleep_mode ? `PCGR_ZERO : SLEEP_KEEP);
    assign gate_bus.pb2_run = periph_bus_two_clock_gate;

    // gated clocks come from a latch and an and, not a flop, by nature
    pcgr_clock_gate u_gate
    (
        .mclk (mclk),
        .gates (gate_bus.snk),
        .gclk (gclk)
    );

    pcgr_read_mask u_mask
    (
        .mclk (mclk),
        .nrst (nrst),
        .gates (gate_bus.snk),
        .periph_rd (periph_rd),
        .periph_sel (periph_sel),
        .periph_rdata (periph_rdata),
        .periph_rd_valid (periph_rd_valid),
        .periph_rd_data (periph_rd_data)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    wire [2*`PCGR_DW-1:0] run_all = {gate_bus.pb2_run, gate_bus.sys_run};

    // the latch shows in the high phase what the enables held at the rising edge
    logic [2*`PCGR_DW-1:0] run_prev;
    always_ff @(posedge mclk)
    begin
        run_prev <= run_all;
    end

    sys_reset_a: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(nrst) |-> system_bus_clock_gate == `PCGR_SYS_GATE_RST)
        else $error("system gate not at reset value");

    pb2_reset_a: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(nrst) |-> periph_bus_two_clock_gate == `PCGR_PB2_GATE_RST)
        else $error("bus-two gate not at reset value");

    byte_lane_a: assert property (@(posedge mclk) disable iff (!nrst)
        sys_wr && reg_be == 4'h1 |=> system_bus_clock_gate[31:8] == $past(system_bus_clock_gate[31:8])
            && system_bus_clock_gate[7:0] == ($past(reg_wdata[7:0]) & SYS_MASK[7:0]))
        else $error("byte write touched wrong lanes");

    read_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
        periph_rd && !run_all[periph_sel] |=> periph_rd_valid && periph_rd_data == `PCGR_ZERO)
        else $error("gated peripheral read not zero");

    busy_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        pb2_defer |=> pb2_write_wait && periph_bus_two_clock_gate == $past(periph_bus_two_clock_gate))
        else $error("bus-two write not held while busy");

    busy_drain_a: assert property (@(posedge mclk) disable iff (!nrst)
        pb2_write_wait && !periph_busy && !reg_wr ##1 1 |-> !pb2_write_wait
            && periph_bus_two_clock_gate == $past(pend_value))
        else $error("held bus-two write not applied");

    read_back_a: assert property (@(posedge mclk) disable iff (!nrst)
        reg_rd && sys_hit |=> reg_rdata == $past(system_bus_clock_gate))
        else $error("read data wrong");

    rd_once_a: assert property (@(posedge mclk) disable iff (!nrst)
        !reg_rd |=> reg_rdata == `PCGR_ZERO)
        else $error("read data outside its cycle");

    sleep_stop_a: assert property (@(posedge mclk) disable iff (!nrst)
        sleep_mode && !system_bus_clock_gate[`PCGR_B_SRAM_SLEEP]
            |-> !gate_bus.sys_run[`PCGR_B_SRAM_SLEEP] && !gate_bus.sys_run[`PCGR_B_FLASH_SLEEP]
                == system_bus_clock_gate[`PCGR_B_FLASH_SLEEP] ^ 1'b1)
        else $error("sram clock runs in sleep");

    awake_run_a: assert property (@(posedge mclk) disable iff (!nrst)
        !sleep_mode |-> gate_bus.sys_run[`PCGR_B_FLASH_SLEEP] && gate_bus.sys_run[`PCGR_B_SRAM_SLEEP])
        else $error("memory clocks stopped while awake");

    reserved_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
        (system_bus_clock_gate & ~SYS_MASK) == `PCGR_ZERO
            && (periph_bus_two_clock_gate & ~PB2_MASK) == `PCGR_ZERO)
        else $error("reserved bit set");

    gate_follow_a: assert property (@(negedge mclk) disable iff (!nrst)
        gclk == run_prev)
        else $error("gated clock high phase does not follow its enable");

    sys_word_a: assert property (@(posedge mclk) disable iff (!nrst)
        sys_wr && reg_be == 4'hf |=> system_bus_clock_gate == ($past(reg_wdata) & SYS_MASK))
        else $error("word write to system gate wrong");

    sys_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
        !(reg_wr && reg_addr == `PCGR_SYS_GATE_OFF) |=> $stable(system_bus_clock_gate))
        else $error("system gate changed without a write");

    pb2_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
        !(reg_wr && reg_addr == `PCGR_PB2_GATE_OFF) && !pb2_write_wait
            |=> $stable(periph_bus_two_clock_gate))
        else $error("bus-two gate changed without a write");

    pb2_free_a: assert property (@(posedge mclk) disable iff (!nrst)
        pb2_wr && !periph_busy |=> !pb2_write_wait)
        else $error("bus-two write held while bus idle");

    pb2_back_a: assert property (@(posedge mclk) disable iff (!nrst)
        reg_rd && pb2_hit |=> reg_rdata == $past(periph_bus_two_clock_gate))
        else $error("bus-two read data wrong");

    rd_unmapped_a: assert property (@(posedge mclk) disable iff (!nrst)
        reg_rd && !sys_hit && !pb2_hit |=> reg_rdata == `PCGR_ZERO)
        else $error("unmapped read not zero");

    rd_valid_a: assert property (@(posedge mclk) disable iff (!nrst)
        periph_rd |=> periph_rd_valid)
        else $error("peripheral read not answered");

    rd_open_a: assert property (@(posedge mclk) disable iff (!nrst)
        periph_rd && run_all[periph_sel] |=> periph_rd_data == $past(periph_rdata))
        else $error("open peripheral read data wrong");

    rd_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
        !periph_rd |=> !periph_rd_valid && periph_rd_data == `PCGR_ZERO)
        else $error("peripheral answer without a read");

    sys_write_c: cover property (@(posedge mclk) disable iff (!nrst) sys_wr && reg_be == 4'hF);
    pb2_defer_c: cover property (@(posedge mclk) disable iff (!nrst) pb2_defer ##[1:8] pb2_drain);
    read_zero_c: cover property (@(posedge mclk) disable iff (!nrst)
        periph_rd && !run_all[periph_sel]);
    sleep_gate_c: cover property (@(posedge mclk) disable iff (!nrst)
        sleep_mode && !gate_bus.sys_run[`PCGR_B_SRAM_SLEEP]);
endmodule // pcgr_top
`default_nettype wire

/* File: dv/test_pcgr_top.sv */
`timescale 1ns/10ps
`default_nettype none
module test_pcgr_top;
    import pcgr_pkg::*;
    // ----------------------------------------
    // writable bits of each gate, reserved bits stay zero
    // ----------------------------------------
    localparam pcgr_word_t SYS_MASK = 32'h017e_0057;
    localparam pcgr_word_t PB2_MASK = 32'h0047_5ae1;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    pcgr_addr_t reg_addr = 8'h00;
    pcgr_word_t reg_wdata = 32'h0000_0000;
    pcgr_be_t reg_be = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic periph_busy = 1'b0;
    logic sleep_mode = 1'b0;
    logic periph_rd = 1'b0;
    pcgr_psel_t periph_sel = 6'h00;
    pcgr_word_t periph_rdata = 32'h0000_0000;
    pcgr_word_t reg_rdata;
    pcgr_word_t periph_rd_data;
    pcgr_word_t sys_gate;
    pcgr_word_t pb2_gate;
    logic periph_rd_valid;
    logic pb2_write_wait;
    logic [63:0] gclk;
    int fail_count = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h2c88_c208;
    pcgr_word_t sys_m = 32'h0000_0014;
    pcgr_word_t pb2_m = 32'h0000_0000;
    pcgr_word_t old;
    pcgr_addr_t a;

    pcgr_top i_pcgr_top (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .periph_busy(periph_busy), .sleep_mode(sleep_mode), .periph_rd(periph_rd),
        .periph_sel(periph_sel), .periph_rdata(periph_rdata),
        .periph_rd_valid(periph_rd_valid), .periph_rd_data(periph_rd_data),
        .system_bus_clock_gate(sys_gate), .periph_bus_two_clock_gate(pb2_gate),
        .pb2_write_wait(pb2_write_wait), .gclk(gclk));

    initial
    begin
        forever #50 mclk = ~mclk;
    end

    // ----------------------------------------
    // expectation helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    endfunction

    function automatic pcgr_word_t merge(input pcgr_word_t o, input pcgr_be_t be,
        input pcgr_word_t d, input pcgr_word_t m);
        pcgr_word_t r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[8*i +: 8] = d[8*i +: 8];
        return r & m;
    endfunction

    // awake, the sram and flash clocks always run; only sleep honours bits 2 and 4
    function automatic pcgr_word_t sys_run(input pcgr_word_t v, input logic slp);
        return slp ? v : (v | 32'h0000_0014);
    endfunction

    task automatic check(input pcgr_word_t seen, input pcgr_word_t exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------------------
    // bus tasks: a write leaves its strobe up so the next access can follow at once
    // ----------------------------------------
    task automatic wr(input pcgr_addr_t ad, input pcgr_be_t be, input pcgr_word_t d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= ad;
        reg_be <= be;
        reg_wdata <= d;
        if (ad == 8'h14)
            sys_m = merge(sys_m, be, d, SYS_MASK);
        if (ad == 8'h18 && !periph_busy)
            pb2_m = merge(pb2_m, be, d, PB2_MASK);
    endtask

    task automatic rd(input pcgr_addr_t ad, input pcgr_word_t exp);
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic idle();
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    task automatic prd(input pcgr_psel_t s, input pcgr_word_t d);
        pcgr_word_t run;
        run = s[5] ? pb2_m : sys_run(sys_m, sleep_mode);
        @(posedge mclk);
        periph_rd <= 1'b1;
        periph_sel <= s;
        periph_rdata <= d;
        @(posedge mclk);
        periph_rd <= 1'b0;
        #1;
        check({31'h0, periph_rd_valid}, 32'h0000_0001);
        check(periph_rd_data, run[s[4:0]] ? d : 32'h0000_0000);
    endtask

    // the gate latch follows one cycle late, so look two edges on, in the high phase
    task automatic chk_clk();
        repeat (2) @(posedge mclk);
        #25;
        check(gclk[31:0], sys_run(sys_m, sleep_mode));
        check(gclk[63:32], pb2_m);
    endtask

    initial
    begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        finish_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        check(sys_gate, 32'h0000_0014);
        check(pb2_gate, 32'h0000_0000);
        chk_clk();
        rd(8'h14, 32'h0000_0014);
        rd(8'h18, 32'h0000_0000);
        @(posedge mclk);
        #1;
        check(reg_rdata, 32'h0000_0000);
        wr(8'h14, 4'hf, 32'hffff_ffff);
        wr(8'h18, 4'hf, 32'hffff_ffff);
        rd(8'h14, SYS_MASK);
        rd(8'h18, PB2_MASK);
        rd(8'h1c, 32'h0000_0000);
        chk_clk();
        @(posedge mclk);
        sleep_mode <= 1'b1;
        wr(8'h14, 4'h1, 32'h0000_0000);
        idle();
        chk_clk();
        prd(6'h02, 32'h1234_5678);
        @(posedge mclk);
        sleep_mode <= 1'b0;
        chk_clk();
        for (int n = 0; n < 40; n++)
        begin
            seed = lfsr(seed);
            a = (seed[1:0] == 2'b00) ? seed[15:8] : (seed[1] ? 8'h18 : 8'h14);
            wr(a, seed[7:4], lfsr(seed));
            rd(a, (a == 8'h14) ? sys_m : ((a == 8'h18) ? pb2_m : 32'h0000_0000));
            prd(seed[21:16], lfsr(seed ^ 32'h5555_5555));
        end
        idle();
        chk_clk();
        @(posedge mclk);
        periph_busy <= 1'b1;
        old = pb2_m;
        wr(8'h18, 4'hf, 32'h0000_5ae1);
        wr(8'h14, 4'hf, 32'h0000_0041);
        idle();
        #1;
        check({31'h0, pb2_write_wait}, 32'h0000_0001);
        check(pb2_gate, old);
        check(sys_gate, 32'h0000_0041);
        rd(8'h18, old);
        @(posedge mclk);
        periph_busy <= 1'b0;
        @(posedge mclk);
        #1;
        pb2_m = 32'h0000_5ae1;
        check(pb2_gate, pb2_m);
        check({31'h0, pb2_write_wait}, 32'h0000_0000);
        // a byte write on an idle bus merges over a write still held from the busy cycle
        @(posedge mclk);
        periph_busy <= 1'b1;
        wr(8'h18, 4'hf, 32'h0000_0001);
        wr(8'h18, 4'h2, 32'h0000_1000);
        periph_busy <= 1'b0;
        idle();
        #1;
        check(pb2_gate, 32'h0000_1001);
        check({31'h0, pb2_write_wait}, 32'h0000_0000);
        finish_test();
    end
endmodule // test_pcgr_top
`default_nettype wire
